// ### core/cwd_config_word_decoder.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module cwd_config_word_decoder (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [13:0] NV_WORD,
   input wire logic SLEEP_MODE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic DBG_PINS_DEDICATED,
   output logic FAILSAFE_CLOCK_MONITOR_EN,
   output logic TWO_SPEED_SWITCHOVER_EN,
   output logic BROWNOUT_DETECT,
   output logic DATA_MEM_READ_BLOCK,
   output logic PROGRAM_MEM_READ_BLOCK,
   output logic PROGRAM_MEM_WRITE_BLOCK,
   output logic MASTER_RESET_PIN_EN,
   output logic MASTER_RESET_PULLUP_EN,
   output logic POWERUP_TIMER_EN,
   output logic WATCHDOG_EN,
   output logic CRYSTAL_EN,
   output logic EXT_CLK_IN_EN,
   output logic INT_OSC_EN,
   output logic RC_OSC_EN,
   output logic PRIMARY_CLK_PIN_IO,
   output logic SECONDARY_CLK_PIN_IO,
   output logic SECONDARY_CLK_PIN_CLKOUT,
   output logic SETUP_VALID
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [13:0] nv_meta;
      logic [13:0] nv_sync;
      logic [13:0] word;
      logic sleep_meta;
      logic sleep_sync;
      cwd_pkg::cwd_load_e load;
      logic [1:0] load_cnt;
      logic sw_bod;
      logic sw_wdt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic dbg_ded;
      logic fcm;
      logic two_speed_switchover_en;
      logic brownout_detect;
      logic dprot;
      logic pprot_rd;
      logic pprot_wr;
      logic rst_pin;
      logic rst_pull;
      logic powerup_timer;
      logic wdt;
      logic xtal;
      logic extclk;
      logic int_rc_clkout_mode;
      logic rcosc;
      logic prim_io;
      logic sec_io;
      logic sec_clko;
      logic valid;
   } cwd_state_s;

   cwd_state_s state_reg;
   cwd_state_s state_next;

   logic xtal_d;
   logic extclk_d;
   logic int_rc_clkout_mode_d;
   logic rcosc_d;
   logic prim_io_d;
   logic sec_io_d;
   logic sec_clko_d;

   // ------------------------------------------------------------
   // Oscillator mode decode of the held word
   // ------------------------------------------------------------
   cwd_osc_decode u_osc (
      .osc_select(state_reg.word[cwd_pkg::OSC_HI:cwd_pkg::OSC_LO]),
      .crystal_en(xtal_d),
      .ext_clk_in_en(extclk_d),
      .int_osc_en(int_rc_clkout_mode_d),
      .rc_osc_en(rcosc_d),
      .prim_pin_io(prim_io_d),
      .sec_pin_io(sec_io_d),
      .sec_pin_clkout(sec_clko_d)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic hit;
      logic [1:0] bod_sel;
      rd = 32'h0;
      hit = 1'b1;
      state_next = state_reg;
      bod_sel = state_reg.word[cwd_pkg::BOD_HI:cwd_pkg::BOD_LO];

      // Word and sleep level come from outside the clock domain
      state_next.nv_meta = NV_WORD;
      state_next.nv_sync = state_reg.nv_meta;
      state_next.sleep_meta = SLEEP_MODE;
      state_next.sleep_sync = state_reg.sleep_meta;

      // Load sequence: let the synchroniser settle, capture once, then hold
      case (state_reg.load)
         cwd_pkg::LD_HOLD: begin
            state_next.load = cwd_pkg::LD_WAIT;
            state_next.load_cnt = 2'h0;
         end
         cwd_pkg::LD_WAIT: begin
            state_next.load_cnt = state_reg.load_cnt + 2'h1;
            if (state_reg.load_cnt == cwd_pkg::LOAD_CYCLES) begin
               state_next.word = state_reg.nv_sync;
               state_next.word[cwd_pkg::UNIMPL_BIT] = 1'b1;
               state_next.load = cwd_pkg::LD_RUN;
            end
         end
         cwd_pkg::LD_RUN: begin
            state_next.valid = 1'b1;
         end
         default: begin
            state_next.load = cwd_pkg::LD_HOLD;
         end
      endcase

      // Decoded fields; a 0 bit means programmed
      state_next.dbg_ded = ~state_reg.word[cwd_pkg::ICD_BIT];
      state_next.fcm = state_reg.word[cwd_pkg::FCM_BIT];
      state_next.two_speed_switchover_en = state_reg.word[cwd_pkg::TWO_SPEED_SWITCHOVER_EN_BIT];
      case (bod_sel)
         cwd_pkg::BOD_ON: state_next.brownout_detect = 1'b1;
         cwd_pkg::BOD_RUN: state_next.brownout_detect = ~state_reg.sleep_sync;
         cwd_pkg::BOD_SW: state_next.brownout_detect = state_reg.sw_bod;
         cwd_pkg::BOD_OFF: state_next.brownout_detect = 1'b0;
         default: state_next.brownout_detect = 1'b0;
      endcase
      state_next.dprot = ~state_reg.word[cwd_pkg::DPROT_BIT];
      state_next.pprot_rd = ~state_reg.word[cwd_pkg::PPROT_BIT];
      state_next.pprot_wr = ~state_reg.word[cwd_pkg::PPROT_BIT];
      state_next.rst_pin = state_reg.word[cwd_pkg::RSTPIN_BIT];
      state_next.rst_pull = state_reg.word[cwd_pkg::RSTPIN_BIT];
      state_next.powerup_timer = ~state_reg.word[cwd_pkg::POWERUP_TIMER_BIT];
      state_next.wdt = state_reg.word[cwd_pkg::WDT_BIT] | state_reg.sw_wdt;
      state_next.xtal = xtal_d;
      state_next.extclk = extclk_d;
      state_next.int_rc_clkout_mode = int_rc_clkout_mode_d;
      state_next.rcosc = rcosc_d;
      state_next.prim_io = prim_io_d;
      state_next.sec_io = sec_io_d;
      state_next.sec_clko = sec_clko_d;
      if (state_reg.load != cwd_pkg::LD_RUN) begin
         // Erased-part defaults until the word is captured
         state_next.valid = 1'b0;
      end

      // APB slave: zero wait states, answer in the access phase
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
      if (PSEL && !PENABLE) begin
         case (PADDR)
            cwd_pkg::SETUP_WORD_ADDR: rd = {18'h0, state_reg.word};
            cwd_pkg::PWR_CTRL_ADDR: rd = {31'h0, state_reg.sw_bod};
            cwd_pkg::WDT_CTRL_ADDR: rd = {31'h0, state_reg.sw_wdt};
            cwd_pkg::STATUS_ADDR: rd = {28'h0, state_reg.wdt, state_reg.brownout_detect,
                                        state_reg.powerup_timer, state_reg.valid};
            default: hit = 1'b0;
         endcase
         state_next.pready = 1'b1;
         state_next.pslverr = ~hit;
         state_next.prdata = PWRITE ? 32'h0 : rd;
      end else if (state_reg.pready) begin
         state_next.prdata = 32'h0;
      end
      if (PSEL && PENABLE && PWRITE && state_reg.pready) begin
         // Setup word and status are read-only; writes there are dropped
         if (PADDR == cwd_pkg::PWR_CTRL_ADDR) begin
            state_next.sw_bod = PWDATA[cwd_pkg::SW_BOD_BIT];
         end
         if (PADDR == cwd_pkg::WDT_CTRL_ADDR) begin
            state_next.sw_wdt = PWDATA[cwd_pkg::SW_WDT_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= '0;
         state_reg.nv_meta <= cwd_pkg::ERASED_WORD;
         state_reg.nv_sync <= cwd_pkg::ERASED_WORD;
         state_reg.word <= cwd_pkg::ERASED_WORD;
         state_reg.load <= cwd_pkg::LD_HOLD;
         state_reg.sw_bod <= cwd_pkg::SW_BOD_RST;
         state_reg.sw_wdt <= cwd_pkg::SW_WDT_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign PRDATA = state_reg.prdata;
   assign PREADY = state_reg.pready;
   assign PSLVERR = state_reg.pslverr;
   assign DBG_PINS_DEDICATED = state_reg.dbg_ded;
   assign FAILSAFE_CLOCK_MONITOR_EN = state_reg.fcm;
   assign TWO_SPEED_SWITCHOVER_EN = state_reg.two_speed_switchover_en;
   assign BROWNOUT_DETECT = state_reg.brownout_detect;
   assign DATA_MEM_READ_BLOCK = state_reg.dprot;
   assign PROGRAM_MEM_READ_BLOCK = state_reg.pprot_rd;
   assign PROGRAM_MEM_WRITE_BLOCK = state_reg.pprot_wr;
   assign MASTER_RESET_PIN_EN = state_reg.rst_pin;
   assign MASTER_RESET_PULLUP_EN = state_reg.rst_pull;
   assign POWERUP_TIMER_EN = state_reg.powerup_timer;
   assign WATCHDOG_EN = state_reg.wdt;
   assign CRYSTAL_EN = state_reg.xtal;
   assign EXT_CLK_IN_EN = state_reg.extclk;
   assign INT_OSC_EN = state_reg.int_rc_clkout_mode;
   assign RC_OSC_EN = state_reg.rcosc;
   assign PRIMARY_CLK_PIN_IO = state_reg.prim_io;
   assign SECONDARY_CLK_PIN_IO = state_reg.sec_io;
   assign SECONDARY_CLK_PIN_CLKOUT = state_reg.sec_clko;
   assign SETUP_VALID = state_reg.valid;
endmodule // cwd_config_word_decoder

// ### include/cwd_pkg.sv
package cwd_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses; printed offset is a word index, four bytes per word)
   // ------------------------------------------------------------
   localparam logic [15:0] SETUP_WORD_IDX = 16'h2007;
   localparam logic [15:0] SETUP_WORD_ADDR = 16'h801c;
   localparam logic [15:0] PWR_CTRL_ADDR = 16'h8020;
   localparam logic [15:0] WDT_CTRL_ADDR = 16'h8024;
   localparam logic [15:0] STATUS_ADDR = 16'h8028;
   localparam int ADDR_W = 16;
   localparam int WORD_W = 14;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int UNIMPL_BIT = 13;
   localparam int ICD_BIT = 12;
   localparam int FCM_BIT = 11;
   localparam int TWO_SPEED_SWITCHOVER_EN_BIT = 10;
   localparam int BOD_HI = 9;
   localparam int BOD_LO = 8;
   localparam int DPROT_BIT = 7;
   localparam int PPROT_BIT = 6;
   localparam int RSTPIN_BIT = 5;
   localparam int POWERUP_TIMER_BIT = 4;
   localparam int WDT_BIT = 3;
   localparam int OSC_HI = 2;
   localparam int OSC_LO = 0;
   localparam int SW_BOD_BIT = 0;
   localparam int SW_WDT_BIT = 0;

   // ------------------------------------------------------------
   // Reset values and load wait count
   // ------------------------------------------------------------
   localparam logic [13:0] ERASED_WORD = 14'h3fff;
   localparam logic SW_BOD_RST = 1'b0;
   localparam logic SW_WDT_RST = 1'b0;
   localparam logic [1:0] LOAD_CYCLES = 2'h2;

   typedef enum logic [1:0] {
      BOD_OFF = 2'b00,
      BOD_SW = 2'b01,
      BOD_RUN = 2'b10,
      BOD_ON = 2'b11
   } cwd_bod_e;

   typedef enum logic [2:0] {
      LOW_POWER_CRYSTAL_MODE = 3'b000,
      STD_CRYSTAL_MODE = 3'b001,
      FAST_CRYSTAL_MODE = 3'b010,
      EXT_CLOCK_IN_MODE = 3'b011,
      INT_RC_PINS_FREE_MODE = 3'b100,
      INT_RC_CLKOUT_MODE = 3'b101,
      RC_NET_PIN_FREE_MODE = 3'b110,
      RC_NET_CLKOUT_MODE = 3'b111
   } cwd_osc_e;

   typedef enum logic [1:0] {
      LD_HOLD = 2'b00,
      LD_WAIT = 2'b01,
      LD_RUN = 2'b10
   } cwd_load_e;
endpackage

// ### core/cwd_osc_decode.sv
`timescale 1ns/10ps
module cwd_osc_decode (
   input wire logic [2:0] osc_select,
   output logic crystal_en,
   output logic ext_clk_in_en,
   output logic int_osc_en,
   output logic rc_osc_en,
   output logic prim_pin_io,
   output logic sec_pin_io,
   output logic sec_pin_clkout
);
   always_comb begin
      crystal_en = 1'b0;
      ext_clk_in_en = 1'b0;
      int_osc_en = 1'b0;
      rc_osc_en = 1'b0;
      prim_pin_io = 1'b0;
      sec_pin_io = 1'b0;
      sec_pin_clkout = 1'b0;
      case (osc_select)
         cwd_pkg::LOW_POWER_CRYSTAL_MODE,
         cwd_pkg::STD_CRYSTAL_MODE,
         cwd_pkg::FAST_CRYSTAL_MODE: begin
            crystal_en = 1'b1;
         end
         cwd_pkg::EXT_CLOCK_IN_MODE: begin
            ext_clk_in_en = 1'b1;
            sec_pin_io = 1'b1;
         end
         cwd_pkg::INT_RC_PINS_FREE_MODE: begin
            int_osc_en = 1'b1;
            prim_pin_io = 1'b1;
            sec_pin_io = 1'b1;
         end
         cwd_pkg::INT_RC_CLKOUT_MODE: begin
            int_osc_en = 1'b1;
            prim_pin_io = 1'b1;
            sec_pin_clkout = 1'b1;
         end
         cwd_pkg::RC_NET_PIN_FREE_MODE: begin
            rc_osc_en = 1'b1;
            sec_pin_io = 1'b1;
         end
         cwd_pkg::RC_NET_CLKOUT_MODE: begin
            rc_osc_en = 1'b1;
            sec_pin_clkout = 1'b1;
         end
         default: begin
            crystal_en = 1'b0;
         end
      endcase
   end
endmodule // cwd_osc_decode

// ### testbench/cwd_props.sv
`timescale 1ns/10ps
module cwd_props (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic DBG_PINS_DEDICATED,
   input wire logic FAILSAFE_CLOCK_MONITOR_EN,
   input wire logic POWERUP_TIMER_EN,
   input wire logic PROGRAM_MEM_READ_BLOCK,
   input wire logic PROGRAM_MEM_WRITE_BLOCK,
   input wire logic MASTER_RESET_PIN_EN,
   input wire logic MASTER_RESET_PULLUP_EN,
   input wire logic CRYSTAL_EN,
   input wire logic EXT_CLK_IN_EN,
   input wire logic INT_OSC_EN,
   input wire logic RC_OSC_EN,
   input wire logic PRIMARY_CLK_PIN_IO,
   input wire logic SECONDARY_CLK_PIN_IO,
   input wire logic SECONDARY_CLK_PIN_CLKOUT,
   input wire logic SETUP_VALID,
   input wire logic PSLVERR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // ------------------------------------------------------------
   // Decoded field relations
   // ------------------------------------------------------------
   a_prog_block_pair: assert property (PROGRAM_MEM_READ_BLOCK == PROGRAM_MEM_WRITE_BLOCK)
      else $error("program read and write block differ");
   a_reset_pin_pullup: assert property (MASTER_RESET_PIN_EN == MASTER_RESET_PULLUP_EN)
      else $error("reset pin and pull-up differ");
   a_osc_one_mode: assert property (SETUP_VALID |->
      $onehot({CRYSTAL_EN, EXT_CLK_IN_EN, INT_OSC_EN, RC_OSC_EN}))
      else $error("oscillator mode not unique");
   a_crystal_pins: assert property (CRYSTAL_EN |->
      !PRIMARY_CLK_PIN_IO && !SECONDARY_CLK_PIN_IO && !SECONDARY_CLK_PIN_CLKOUT)
      else $error("crystal mode frees a clock pin");
   a_ext_clk_pins: assert property (EXT_CLK_IN_EN |->
      !PRIMARY_CLK_PIN_IO && SECONDARY_CLK_PIN_IO && !SECONDARY_CLK_PIN_CLKOUT)
      else $error("external clock pin use wrong");
   a_int_osc_pins: assert property (INT_OSC_EN |->
      PRIMARY_CLK_PIN_IO && (SECONDARY_CLK_PIN_IO != SECONDARY_CLK_PIN_CLKOUT))
      else $error("internal oscillator pin use wrong");
   a_rc_osc_pins: assert property (RC_OSC_EN |->
      !PRIMARY_CLK_PIN_IO && (SECONDARY_CLK_PIN_IO != SECONDARY_CLK_PIN_CLKOUT))
      else $error("rc oscillator pin use wrong");
   a_setup_held: assert property (SETUP_VALID && $past(SETUP_VALID) |->
      $stable({DBG_PINS_DEDICATED, FAILSAFE_CLOCK_MONITOR_EN, POWERUP_TIMER_EN,
      PROGRAM_MEM_READ_BLOCK, CRYSTAL_EN, INT_OSC_EN, SECONDARY_CLK_PIN_CLKOUT}))
      else $error("static setup changed while running");

   c_valid: cover property ($rose(SETUP_VALID));
   c_int_clkout: cover property (INT_OSC_EN && SECONDARY_CLK_PIN_CLKOUT);
   c_ext_clk: cover property (EXT_CLK_IN_EN);
   c_bus_err: cover property (PSLVERR);
endmodule // cwd_props

bind cwd_config_word_decoder cwd_props cwd_props_inst (.CLK, .RST_B, .DBG_PINS_DEDICATED,
   .FAILSAFE_CLOCK_MONITOR_EN, .POWERUP_TIMER_EN, .PROGRAM_MEM_READ_BLOCK,
   .PROGRAM_MEM_WRITE_BLOCK, .MASTER_RESET_PIN_EN, .MASTER_RESET_PULLUP_EN, .CRYSTAL_EN,
   .EXT_CLK_IN_EN, .INT_OSC_EN, .RC_OSC_EN, .PRIMARY_CLK_PIN_IO, .SECONDARY_CLK_PIN_IO,
   .SECONDARY_CLK_PIN_CLKOUT, .SETUP_VALID, .PSLVERR);

// ### testbench/cwd_config_word_decoder_test.sv
`timescale 1ns/10ps
module cwd_config_word_decoder_test;
   logic CLK, RST_B, SLEEP_MODE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SETUP_VALID;
   logic [13:0] NV_WORD;
   logic [15:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [17:0] obs, e;
   logic [13:0] w;
   logic er, sw, sb;
   int err_total, num_checks, cyc;

   cwd_config_word_decoder cwd_config_word_decoder_inst (.CLK(CLK), .RST_B(RST_B),
      .NV_WORD(NV_WORD), .SLEEP_MODE(SLEEP_MODE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .DBG_PINS_DEDICATED(obs[17]), .FAILSAFE_CLOCK_MONITOR_EN(obs[16]),
      .TWO_SPEED_SWITCHOVER_EN(obs[15]), .BROWNOUT_DETECT(obs[14]),
      .DATA_MEM_READ_BLOCK(obs[13]), .PROGRAM_MEM_READ_BLOCK(obs[12]),
      .PROGRAM_MEM_WRITE_BLOCK(obs[11]), .MASTER_RESET_PIN_EN(obs[10]),
      .MASTER_RESET_PULLUP_EN(obs[9]), .POWERUP_TIMER_EN(obs[8]), .WATCHDOG_EN(obs[7]),
      .CRYSTAL_EN(obs[6]), .EXT_CLK_IN_EN(obs[5]), .INT_OSC_EN(obs[4]), .RC_OSC_EN(obs[3]),
      .PRIMARY_CLK_PIN_IO(obs[2]), .SECONDARY_CLK_PIN_IO(obs[1]),
      .SECONDARY_CLK_PIN_CLKOUT(obs[0]), .SETUP_VALID(SETUP_VALID));

   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   // ------------------------------------------------------------
   // Expectation, comparison and verdict
   // ------------------------------------------------------------
   function automatic logic [17:0] expect_out(logic [13:0] v, logic s_w, logic s_b, logic slp);
      logic [2:0] o;
      logic brownout_detect;
      o = v[2:0];
      case (v[9:8])
         2'h3: brownout_detect = 1'b1;
         2'h2: brownout_detect = ~slp;
         2'h1: brownout_detect = s_b;
         default: brownout_detect = 1'b0;
      endcase
      return {~v[12], v[11], v[10], brownout_detect, ~v[7], ~v[6], ~v[6], v[5], v[5], ~v[4], v[3] | s_w,
         o < 3'h3, o == 3'h3, o[2:1] == 2'h2, o[2:1] == 2'h3, o[2:1] == 2'h2,
         o == 3'h3 || o == 3'h4 || o == 3'h6, o[2] & o[0]};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         print_verdict;
      end
   end

   // ------------------------------------------------------------
   // Bus and reset drivers
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic x);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      r = PRDATA;
      x = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      check("bus answer", {31'h0, PREADY}, 32'h1);
   endtask

   task automatic reset_to(input logic [13:0] v);
      int n;
      @(posedge CLK);
      RST_B <= 1'b0;
      NV_WORD <= v;
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      n = 0;
      while (SETUP_VALID !== 1'b1 && n < 50) begin
         @(posedge CLK);
         n++;
      end
      check("setup valid", {31'h0, SETUP_VALID}, 32'h1);
      repeat (2) @(posedge CLK);
   endtask

   // ------------------------------------------------------------
   // Main sequence: every oscillator and brown-out code, erased and blank words
   // ------------------------------------------------------------
   initial begin
      RST_B = 1'b0;
      NV_WORD = 14'h3fff;
      SLEEP_MODE = 1'b0;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      {cyc, err_total, num_checks} = '0;
      void'($urandom(32'h1cc42da0));
      for (int i = 0; i < 12; i++) begin
         w = 14'($urandom);
         if (i < 8) begin
            w[2:0] = 3'(i);
            w[9:8] = 2'(i);
            w[3] = i[2];
         end
         if (i == 8) w = 14'h3fff;
         if (i == 9) w = 14'h0;
         SLEEP_MODE <= 1'($urandom);
         reset_to(w);
         check("outputs", 32'(obs), 32'(expect_out(w, 1'b0, 1'b0, SLEEP_MODE)));
         apb(1'b1, cwd_pkg::SETUP_WORD_ADDR, 32'h0, rd, er);
         NV_WORD <= ~w;
         apb(1'b0, cwd_pkg::SETUP_WORD_ADDR, 32'h0, rd, er);
         check("setup word", rd, {18'h0, 1'b1, w[12:0]});
         check("mapped error", {31'h0, er}, 32'h0);
         sw = 1'($urandom);
         sb = 1'($urandom);
         apb(1'b1, cwd_pkg::WDT_CTRL_ADDR, {31'h0, sw}, rd, er);
         apb(1'b1, cwd_pkg::PWR_CTRL_ADDR, {31'h0, sb}, rd, er);
         SLEEP_MODE <= ~SLEEP_MODE;
         repeat (6) @(posedge CLK);
         e = expect_out(w, sw, sb, SLEEP_MODE);
         check("live outputs", 32'(obs), 32'(e));
         apb(1'b0, cwd_pkg::STATUS_ADDR, 32'h0, rd, er);
         check("status", rd, {28'h0, e[7], e[14], e[8], 1'b1});
         apb(1'b0, cwd_pkg::PWR_CTRL_ADDR, 32'h0, rd, er);
         check("brown-out sw bit", rd, {31'h0, sb});
         apb(1'b0, 16'h8030, 32'h0, rd, er);
         check("unmapped error", {31'h0, er}, 32'h1);
         check("unmapped data", rd, 32'h0);
      end
      print_verdict;
   end
endmodule // cwd_config_word_decoder_test
